/* File: design/tcp_timer.sv */
// timer counter with compare, pwm and single-pulse output channels
//
// Summary of operation
// - on match mode 000 holds, 001 sets, 010 clears, 011 toggles output
// - match sets channel compare flag; flag with its mask bit set raises interrupt request
// - compare write is immediate unless buffered, then waits for update
// - update event never changes reference or channel output in compare mode
// - compare acts at the very count where counter equals compare value
// - mode 110 selects pwm mode 1, 111 pwm mode 2, per channel
// - pwm period follows reload value, duty follows compare value
// - buffered values reach shadows only on update; software primes with update
// - output is reference xor polarity, driven only while output enabled
// - pwm reference changes only on compare change, leaving frozen mode or a fast-enabled trigger
// - alignment 00 edge, nonzero center; nonzero values differ only in flag
// - alignment 01 sets compare flag only while counting down
// - mode 1 up: high below compare; 1 above reload, 0 at compare zero
// - mode 1 down: low above compare, else high; no zero duty
// - center mode direction is hardware owned; start uses current direction
// - counter write in center mode: above reload keeps direction, 0/reload set it
// - single-pulse bit stops counter at next hardware update event (overflow or underflow); a software update does not stop it
// - slave mode 110 is trigger start; trigger select 110 is input two
// - single pulse delay equals compare, length reload minus compare plus one
// - trigger edge sets the counter run bit after sync latency
// - fast enable in pwm forces post-match level on the trigger
// - mode 101 forces reference high, 100 forces it low
`timescale 1ns/100ps
`include "tcp_consts.svh"

module tcp_timer
    import tcp_pkg::*;
#(
    parameter int CNT_W  = 16,
    parameter int NUM_CH = 2,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESETN,
    // register port
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [31:0]       WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [31:0]       RDATA,
    // trigger pin
    input  wire logic              INPUT_TWO,
    // channel pins and interrupt request
    output logic      [NUM_CH-1:0] CH_OUT,
    output logic      [NUM_CH-1:0] CH_OE,
    output logic                   COMPARE_IRQ
);

    // control state
    logic              run_r;
    logic              spm_r;
    logic              dir_r;
    tcp_align_e        aln_r;
    logic              rbe_r;
    logic [2:0]        sms_r;
    logic [2:0]        ts_r;
    logic              tpol_r;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  arr_buf_r;
    logic [CNT_W-1:0]  arr_sh_r;
    logic [CNT_W-1:0]  psc_r;
    logic [CNT_W-1:0]  psc_cnt_r;
    logic              moved_r;
    logic [NUM_CH-1:0] flag_r;
    logic [NUM_CH-1:0] mask_r;
    logic [NUM_CH-1:0] flag_set;
    tcp_chcfg_s        cfg_r    [NUM_CH];
    logic [CNT_W-1:0]  cmp_buf_r[NUM_CH];
    logic [CNT_W-1:0]  cmp_sh_r [NUM_CH];

    // decoded strobes
    logic wr_ctrl;
    logic wr_cnt;
    logic ug;
    logic tick;
    logic centered;
    logic at_top;
    logic at_bot;
    logic uev_hw;
    logic uev;

    assign wr_ctrl  = WR && (ADDR == `TCP_OFS_CTRL);
    assign wr_cnt   = WR && (ADDR == `TCP_OFS_COUNT);
    assign ug       = WR && (ADDR == `TCP_OFS_EVGEN) && WDATA[`TCP_EVGEN_UG];
    assign tick     = run_r && (psc_cnt_r == psc_r);
    assign centered = (aln_r != TCP_EDGE);
    assign at_top   = (cnt_r >= arr_sh_r);
    assign at_bot   = (cnt_r == '0);
    assign uev_hw   = tick && (dir_r ? at_bot : at_top);
    assign uev      = uev_hw || ug;

    // trigger pin: three flops, level accepted once stages two and three agree
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic lvl_prev_r;
    logic trig;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            s1_r       <= 1'b0;
            s2_r       <= 1'b0;
            s3_r       <= 1'b0;
            lvl_r      <= 1'b0;
            lvl_prev_r <= 1'b0;
        end else begin
            s1_r       <= INPUT_TWO;
            s2_r       <= s1_r;
            s3_r       <= s2_r;
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
            lvl_prev_r <= lvl_r;
        end
    end

    // active edge of the polarity-corrected input, only when selected
    assign trig = (sms_r == `TCP_SMS_TRIGGER) &&
                  (ts_r == `TCP_TS_INPUT_TWO) &&
                  ((lvl_r ^ tpol_r) && !(lvl_prev_r ^ tpol_r));

    // prescaler divider gives the counter clock enable
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            psc_cnt_r <= '0;
        end else if (!run_r || ug || psc_cnt_r == psc_r) begin
            psc_cnt_r <= '0;
        end else begin
            psc_cnt_r <= psc_cnt_r + 1'b1;
        end
    end

    // configuration registers
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            spm_r  <= 1'b0;
            aln_r  <= TCP_EDGE;
            rbe_r  <= 1'b0;
            sms_r  <= 3'h0;
            ts_r   <= 3'h0;
            tpol_r <= 1'b0;
            psc_r  <= `TCP_RST_ZERO;
            mask_r <= '0;
        end else if (WR) begin
            case (ADDR)
                `TCP_OFS_CTRL: begin
                    spm_r <= WDATA[`TCP_CTRL_SPM];
                    aln_r <= tcp_align_e'(
                        WDATA[`TCP_CTRL_ALN_HI:`TCP_CTRL_ALN_LO]);
                    rbe_r <= WDATA[`TCP_CTRL_RBE];
                end
                `TCP_OFS_SLAVE: begin
                    sms_r  <= WDATA[`TCP_SLAVE_SMS_HI:`TCP_SLAVE_SMS_LO];
                    ts_r   <= WDATA[`TCP_SLAVE_TS_HI:`TCP_SLAVE_TS_LO];
                    tpol_r <= WDATA[`TCP_SLAVE_TPOL];
                end
                `TCP_OFS_PRESC:  psc_r  <= WDATA[CNT_W-1:0];
                `TCP_OFS_MASK:   mask_r <= WDATA[NUM_CH-1:0];
                default: begin
                end
            endcase
        end
    end

    // run bit: trigger start wins over the single-pulse stop and writes
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            run_r <= 1'b0;
        end else if (trig) begin
            run_r <= 1'b1;
        end else if (uev_hw && spm_r) begin
            run_r <= 1'b0;
        end else if (wr_ctrl) begin
            run_r <= WDATA[`TCP_CTRL_RUN];
        end
    end

    // reload value, buffered or direct
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            arr_buf_r <= `TCP_RST_RELOAD;
            arr_sh_r  <= `TCP_RST_RELOAD;
        end else begin
            if (WR && ADDR == `TCP_OFS_RELOAD) begin
                arr_buf_r <= WDATA[CNT_W-1:0];
            end
            if (!rbe_r || uev) begin
                arr_sh_r <= arr_buf_r;
            end
        end
    end

    // counter and direction
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            cnt_r   <= '0;
            dir_r   <= 1'b0;
            moved_r <= 1'b0;
        end else begin
            moved_r <= tick;
            if (ug) begin
                cnt_r <= dir_r ? arr_sh_r : '0;
            end else if (wr_cnt) begin
                cnt_r <= WDATA[CNT_W-1:0];
                // direction follows only the two end values, no update event
                if (centered && WDATA[CNT_W-1:0] == '0) begin
                    dir_r <= 1'b0;
                end else if (centered && WDATA[CNT_W-1:0] == arr_sh_r) begin
                    dir_r <= 1'b1;
                end
            end else if (tick) begin
                if (!dir_r) begin
                    if (!at_top) begin
                        cnt_r <= cnt_r + 1'b1;
                    end else if (centered) begin
                        cnt_r <= cnt_r - 1'b1;
                        dir_r <= 1'b1;
                    end else begin
                        cnt_r <= '0;
                    end
                end else begin
                    if (!at_bot) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else if (centered) begin
                        cnt_r <= cnt_r + 1'b1;
                        dir_r <= 1'b0;
                    end else begin
                        cnt_r <= arr_sh_r;
                    end
                end
            end
            // software owns direction only in edge-aligned mode
            if (wr_ctrl && !centered && !wr_cnt && !ug && !tick) begin
                dir_r <= WDATA[`TCP_CTRL_DIR];
            end
        end
    end

    // per-channel compare stage
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            logic       wr_mode;
            logic       wr_cmp;
            logic       match;
            logic       pwm;
            logic       res;
            logic       res_prev_r;
            tcp_mode_e  mode_prev_r;
            logic       ref_r;
            logic       flag_ok;
            tcp_mode_e  m;

            assign m       = cfg_r[g].mode;
            assign wr_mode = WR && ADDR == `TCP_OFS_CHMODE +
                             ADDR_W'(g) * `TCP_CH_STRIDE;
            assign wr_cmp  = WR && ADDR == `TCP_OFS_CMP +
                             ADDR_W'(g) * `TCP_CH_STRIDE;
            // act only on the count that just arrived at the compare value
            assign match   = moved_r && (cnt_r == cmp_sh_r[g]);
            assign pwm     = (m == TCP_PWM1) || (m == TCP_PWM2);
            // mode 1 level; edge cases fall out of the plain compare
            assign res     = (dir_r ? !(cnt_r > cmp_sh_r[g])
                                    : (cnt_r < cmp_sh_r[g]))
                             ^ (m == TCP_PWM2);
            always_comb begin
                case (aln_r)
                    TCP_CENTER_DN: flag_ok = dir_r;
                    TCP_CENTER_UP: flag_ok = !dir_r;
                    default:       flag_ok = 1'b1;
                endcase
            end
            assign flag_set[g] = match && flag_ok;

            always_ff @(posedge CLOCK or negedge RESETN) begin
                if (!RESETN) begin
                    cfg_r[g]     <= '0;
                    cmp_buf_r[g] <= `TCP_RST_ZERO;
                    cmp_sh_r[g]  <= `TCP_RST_ZERO;
                end else begin
                    if (wr_mode) begin
                        cfg_r[g] <= tcp_chcfg_s'(WDATA[6:0]);
                    end
                    if (wr_cmp) begin
                        cmp_buf_r[g] <= WDATA[CNT_W-1:0];
                    end
                    if (!cfg_r[g].buf_en || uev) begin
                        cmp_sh_r[g] <= cmp_buf_r[g];
                    end
                end
            end

            // update event deliberately absent here
            always_ff @(posedge CLOCK or negedge RESETN) begin
                if (!RESETN) begin
                    ref_r       <= 1'b0;
                    res_prev_r  <= 1'b0;
                    mode_prev_r <= TCP_FROZEN;
                end else begin
                    res_prev_r  <= res;
                    mode_prev_r <= m;
                    case (m)
                        TCP_FROZEN: begin
                        end
                        TCP_SET_ACT:  if (match) ref_r <= 1'b1;
                        TCP_SET_INA:  if (match) ref_r <= 1'b0;
                        TCP_TOGGLE:   if (match) ref_r <= !ref_r;
                        TCP_FORCE_LO: ref_r <= 1'b0;
                        TCP_FORCE_HI: ref_r <= 1'b1;
                        TCP_PWM1, TCP_PWM2: begin
                            if (trig && cfg_r[g].fast) begin
                                // level the first match would give
                                ref_r <= dir_r ^ (m == TCP_PWM2);
                            end else if (res != res_prev_r ||
                                         mode_prev_r == TCP_FROZEN) begin
                                ref_r <= res;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end

            always_ff @(posedge CLOCK or negedge RESETN) begin
                if (!RESETN) begin
                    CH_OUT[g] <= 1'b0;
                    CH_OE[g]  <= 1'b0;
                end else begin
                    CH_OUT[g] <= ref_r ^ cfg_r[g].pol;
                    CH_OE[g]  <= cfg_r[g].oe;
                end
            end
        end
    endgenerate

    // flags: a match in the clearing cycle survives
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            flag_r      <= '0;
            COMPARE_IRQ <= 1'b0;
        end else begin
            if (WR && ADDR == `TCP_OFS_FLAG) begin
                flag_r <= (flag_r & ~WDATA[NUM_CH-1:0]) | flag_set;
            end else begin
                flag_r <= flag_r | flag_set;
            end
            COMPARE_IRQ <= |(flag_r & mask_r);
        end
    end

    // read port, data one cycle after the strobe
    logic [31:0] rd_nxt;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (ADDR)
            `TCP_OFS_CTRL: begin
                rd_nxt[`TCP_CTRL_RUN] = run_r;
                rd_nxt[`TCP_CTRL_SPM] = spm_r;
                rd_nxt[`TCP_CTRL_DIR] = dir_r;
                rd_nxt[`TCP_CTRL_ALN_HI:`TCP_CTRL_ALN_LO] = aln_r;
                rd_nxt[`TCP_CTRL_RBE] = rbe_r;
            end
            `TCP_OFS_SLAVE: begin
                rd_nxt[`TCP_SLAVE_SMS_HI:`TCP_SLAVE_SMS_LO] = sms_r;
                rd_nxt[`TCP_SLAVE_TS_HI:`TCP_SLAVE_TS_LO]   = ts_r;
                rd_nxt[`TCP_SLAVE_TPOL] = tpol_r;
            end
            `TCP_OFS_FLAG:   rd_nxt[NUM_CH-1:0] = flag_r;
            `TCP_OFS_MASK:   rd_nxt[NUM_CH-1:0] = mask_r;
            `TCP_OFS_COUNT:  rd_nxt[CNT_W-1:0]  = cnt_r;
            `TCP_OFS_RELOAD: rd_nxt[CNT_W-1:0]  = arr_buf_r;
            `TCP_OFS_PRESC:  rd_nxt[CNT_W-1:0]  = psc_r;
            default: begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (ADDR == `TCP_OFS_CHMODE +
                        ADDR_W'(i) * `TCP_CH_STRIDE) begin
                        rd_nxt[6:0] = cfg_r[i];
                    end
                    if (ADDR == `TCP_OFS_CMP +
                        ADDR_W'(i) * `TCP_CH_STRIDE) begin
                        rd_nxt[CNT_W-1:0] = cmp_buf_r[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            RDATA <= rd_nxt;
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

endmodule

/* File: design/tcp_consts.svh */
// register offsets, field positions and reset values
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

`define TCP_OFS_CTRL      8'h00
`define TCP_OFS_EVGEN     8'h04
`define TCP_OFS_SLAVE     8'h08
`define TCP_OFS_FLAG      8'h0C
`define TCP_OFS_MASK      8'h10
`define TCP_OFS_COUNT     8'h14
`define TCP_OFS_RELOAD    8'h18
`define TCP_OFS_PRESC     8'h1C
`define TCP_OFS_CHMODE    8'h20
`define TCP_OFS_CMP       8'h40
`define TCP_CH_STRIDE     8'h04

`define TCP_CTRL_RUN      0
`define TCP_CTRL_SPM      1
`define TCP_CTRL_DIR      2
`define TCP_CTRL_ALN_LO   3
`define TCP_CTRL_ALN_HI   4
`define TCP_CTRL_RBE      5
`define TCP_EVGEN_UG      0
`define TCP_SLAVE_SMS_LO  0
`define TCP_SLAVE_SMS_HI  2
`define TCP_SLAVE_TS_LO   4
`define TCP_SLAVE_TS_HI   6
`define TCP_SLAVE_TPOL    8
`define TCP_CHM_MODE_LO   0
`define TCP_CHM_MODE_HI   2
`define TCP_CHM_BUF       3
`define TCP_CHM_FAST      4
`define TCP_CHM_POL       5
`define TCP_CHM_OE        6

`define TCP_SMS_TRIGGER   3'h6
`define TCP_TS_INPUT_TWO  3'h6
`define TCP_RST_RELOAD    16'hFFFF
`define TCP_RST_ZERO      16'h0000

`endif

/* File: design/tcp_pkg.sv */
// types shared by the compare/pwm/single-pulse timer channel stage
package tcp_pkg;

    typedef enum logic [2:0] {
        TCP_FROZEN   = 3'b000,
        TCP_SET_ACT  = 3'b001,
        TCP_SET_INA  = 3'b010,
        TCP_TOGGLE   = 3'b011,
        TCP_FORCE_LO = 3'b100,
        TCP_FORCE_HI = 3'b101,
        TCP_PWM1     = 3'b110,
        TCP_PWM2     = 3'b111
    } tcp_mode_e;

    typedef enum logic [1:0] {
        TCP_EDGE      = 2'b00,
        TCP_CENTER_DN = 2'b01,
        TCP_CENTER_UP = 2'b10,
        TCP_CENTER_UD = 2'b11
    } tcp_align_e;

    typedef struct packed {
        logic      oe;
        logic      pol;
        logic      fast;
        logic      buf_en;
        tcp_mode_e mode;
    } tcp_chcfg_s;

endpackage

/* File: testbench/tcp_timer_monitor.sv */
// port-level assertion checker for the timer compare/pwm channel
`timescale 1ns/100ps
`include "tcp_consts.svh"

module tcp_timer_monitor #(
    parameter int NUM_CH = 2,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic              CLOCK,
    input wire logic              RESETN,
    // register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0]       WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [31:0]       RDATA,
    // pins
    input wire logic              INPUT_TWO,
    input wire logic [NUM_CH-1:0] CH_OUT,
    input wire logic [NUM_CH-1:0] CH_OE,
    input wire logic              COMPARE_IRQ
);
    logic [6:0]        cfg0_r;
    logic [NUM_CH-1:0] mask_r;

    // mirrors of software writes, so pins can be tied to their cause
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            cfg0_r <= 7'h00;
        end else if (WR && ADDR == ADDR_W'(`TCP_OFS_CHMODE)) begin
            cfg0_r <= WDATA[6:0];
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            mask_r <= '0;
        end else if (WR && ADDR == ADDR_W'(`TCP_OFS_MASK)) begin
            mask_r <= WDATA[NUM_CH-1:0];
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    evgen_zero_a: assert property (($past(RD)
        && $past(ADDR) == ADDR_W'(`TCP_OFS_EVGEN)) |-> RDATA == 32'h0000_0000)
        else $error("event register read not zero");
    unmapped_zero_a: assert property (($past(RD)
        && $past(ADDR) == ADDR_W'(8'hFC)) |-> RDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    ctrl_upper_a: assert property (($past(RD)
        && $past(ADDR) == ADDR_W'(`TCP_OFS_CTRL)) |-> RDATA[31:6] == '0)
        else $error("control read has upper bits set");
    irq_mask_a: assert property (COMPARE_IRQ |-> $past(mask_r) != '0)
        else $error("interrupt request with all channels masked");
    // settle time: config needs two edges to reach the pins
    oe_follow_a: assert property (($past(cfg0_r, 2) == cfg0_r
        && $past(cfg0_r) == cfg0_r) |-> CH_OE[0] == cfg0_r[6])
        else $error("output enable does not follow channel config");
    forced_level_a: assert property (($past(cfg0_r, 2) == cfg0_r
        && $past(cfg0_r) == cfg0_r && cfg0_r[2:1] == 2'h2)
        |-> CH_OUT[0] == (cfg0_r[0] ^ cfg0_r[5]))
        else $error("forced level wrong on channel output");
    frozen_hold_a: assert property (($past(cfg0_r, 2) == cfg0_r
        && $past(cfg0_r) == cfg0_r && cfg0_r[2:0] == 3'h0)
        |-> $stable(CH_OUT[0]))
        else $error("channel output moved in frozen mode");
endmodule

bind tcp_timer tcp_timer_monitor #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) mon_u (
    .CLOCK       (CLOCK),
    .RESETN      (RESETN),
    .ADDR        (ADDR),
    .WDATA       (WDATA),
    .WR          (WR),
    .RD          (RD),
    .RDATA       (RDATA),
    .INPUT_TWO   (INPUT_TWO),
    .CH_OUT      (CH_OUT),
    .CH_OE       (CH_OE),
    .COMPARE_IRQ (COMPARE_IRQ)
);

/* File: testbench/tcp_timer_tb_top.sv */
// self-checking bench for the timer compare/pwm channel
`timescale 1ns/100ps
`include "tcp_consts.svh"

module tcp_timer_tb_top;
    logic        clock     = 1'b0;
    logic        resetn    = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [31:0] wdata     = 32'h0000_0000;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        input_two = 1'b0;
    logic [31:0] rdata;
    logic [1:0]  ch_out;
    logic [1:0]  ch_oe;
    logic        irq;
    int          n_errors  = 0;
    int          checked   = 0;
    int          cycles    = 0;
    // compare-mode rows: channel config and the output after one match
    logic [7:0]  mode_tab [10] = '{8'h44, 8'h41, 8'h42, 8'h43, 8'h43,
                                   8'h40, 8'h45, 8'h60, 8'h63, 8'h05};
    logic [0:9]  out_tab       = 10'h14B;
    int          cmp_tab  [3]  = '{3, 12, 0};
    int          high_tab [3]  = '{6, 20, 0};

    tcp_timer #(.CNT_W(16), .NUM_CH(2), .ADDR_W(8)) dut_u (
        .CLOCK       (clock),
        .RESETN      (resetn),
        .ADDR        (addr),
        .WDATA       (wdata),
        .WR          (wr),
        .RD          (rd),
        .RDATA       (rdata),
        .INPUT_TWO   (input_two),
        .CH_OUT      (ch_out),
        .CH_OE       (ch_oe),
        .COMPARE_IRQ (irq)
    );

    always #5 clock = ~clock;

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    // ends just past the edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    // count 0 to about 7: passes compare 4 once, never wraps at 9
    task automatic run_window();
        wr_reg(`TCP_OFS_COUNT, 32'h0000_0000);
        wr_reg(`TCP_OFS_CTRL, 32'h0000_0001);
        cyc(5);
        wr_reg(`TCP_OFS_CTRL, 32'h0000_0000);
        cyc(3);
    endtask

    initial begin
        int i;
        int k;
        int highs;
        logic seen;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        wr_reg(`TCP_OFS_RELOAD, 32'h0000_0009);
        wr_reg(`TCP_OFS_CMP, 32'h0000_0004);
        wr_reg(`TCP_OFS_MASK, 32'h0000_0001);
        for (i = 0; i < 10; i++) begin
            wr_reg(`TCP_OFS_CHMODE, {24'h00_0000, mode_tab[i]});
            run_window();
            check({30'h0000_0000, ch_oe[0], ch_out[0]},
                  {30'h0000_0000, mode_tab[i][6], out_tab[i]});
        end
        check({31'h0000_0000, irq}, 32'h0000_0001);
        wr_reg(`TCP_OFS_FLAG, 32'h0000_0001);
        cyc(3);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        wr_reg(`TCP_OFS_CHMODE, 32'h0000_004B);
        wr_reg(`TCP_OFS_CMP, 32'h0000_0014);
        run_window();
        check({31'h0000_0000, ch_out[0]}, 32'h0000_0000);
        wr_reg(`TCP_OFS_EVGEN, 32'h0000_0001);
        run_window();
        check({31'h0000_0000, ch_out[0]}, 32'h0000_0000);
        // only a move out of frozen resyncs a stale reference at once
        wr_reg(`TCP_OFS_CHMODE, 32'h0000_0048);
        wr_reg(`TCP_OFS_CHMODE, 32'h0000_004E);
        wr_reg(`TCP_OFS_CHMODE + `TCP_CH_STRIDE, 32'h0000_004F);
        for (k = 0; k < 3; k++) begin
            wr_reg(`TCP_OFS_CMP, cmp_tab[k]);
            wr_reg(`TCP_OFS_CMP + `TCP_CH_STRIDE, cmp_tab[k]);
            wr_reg(`TCP_OFS_EVGEN, 32'h0000_0001);
            wr_reg(`TCP_OFS_CTRL, 32'h0000_0021);
            cyc(4);
            highs = 0;
            for (i = 0; i < 20; i++) begin
                highs += int'(ch_out[0]);
                check({31'h0000_0000, ch_out[1]},
                      {31'h0000_0000, ~ch_out[0]});
                cyc(1);
            end
            check(highs, high_tab[k]);
            wr_reg(`TCP_OFS_CTRL, 32'h0000_0000);
        end
        wr_reg(`TCP_OFS_SLAVE, 32'h0000_0066);
        wr_reg(`TCP_OFS_CMP, 32'h0000_0008);
        // second pass adds fast enable: pulse must lead the compare
        for (k = 0; k < 2; k++) begin
            wr_reg(`TCP_OFS_CHMODE, 32'h0000_004F | 32'(k << 4));
            wr_reg(`TCP_OFS_CTRL, 32'h0000_0002);
            wr_reg(`TCP_OFS_EVGEN, 32'h0000_0001);
            repeat (2) @(posedge clock);
            input_two <= 1'b1;
            cyc(9);
            check({31'h0000_0000, ch_out[0]}, k);
            seen = ch_out[0];
            for (i = 0; i < 30; i++) begin
                seen = seen | ch_out[0];
                cyc(1);
            end
            check({31'h0000_0000, seen}, 32'h0000_0001);
            check({31'h0000_0000, ch_out[0]}, 32'h0000_0000);
            rd_reg(`TCP_OFS_CTRL, 32'h0000_0002);
            @(posedge clock);
            input_two <= 1'b0;
            cyc(8);
        end
        // center mode: direction belongs to hardware and counter writes
        wr_reg(`TCP_OFS_CTRL, 32'h0000_0008);
        wr_reg(`TCP_OFS_COUNT, 32'h0000_0009);
        rd_reg(`TCP_OFS_CTRL, 32'h0000_000C);
        wr_reg(`TCP_OFS_CTRL, 32'h0000_0008);
        rd_reg(`TCP_OFS_CTRL, 32'h0000_000C);
        wr_reg(`TCP_OFS_COUNT, 32'h0000_0020);
        rd_reg(`TCP_OFS_CTRL, 32'h0000_000C);
        wr_reg(`TCP_OFS_COUNT, 32'h0000_0000);
        rd_reg(`TCP_OFS_CTRL, 32'h0000_0008);
        // mode 01: match counting up leaves flag clear, down sets it
        wr_reg(`TCP_OFS_FLAG, 32'h0000_0003);
        wr_reg(`TCP_OFS_CMP, 32'h0000_0004);
        wr_reg(`TCP_OFS_EVGEN, 32'h0000_0001);
        for (k = 0; k < 2; k++) begin
            wr_reg(`TCP_OFS_CTRL, 32'h0000_0009);
            cyc(5);
            wr_reg(`TCP_OFS_CTRL, 32'h0000_0008);
            cyc(2);
            rd_reg(`TCP_OFS_FLAG, k);
        end
        @(posedge clock);
        resetn <= 1'b0;
        cyc(3);
        check({28'h000_0000, ch_oe, ch_out}, 32'h0000_0000);
        @(posedge clock);
        resetn <= 1'b1;
        wr_reg(8'hFC, 32'hFFFF_FFFF);
        rd_reg(`TCP_OFS_RELOAD, 32'h0000_FFFF);
        rd_reg(`TCP_OFS_CTRL, 32'h0000_0000);
        rd_reg(`TCP_OFS_CHMODE, 32'h0000_0000);
        rd_reg(`TCP_OFS_EVGEN, 32'h0000_0000);
        rd_reg(8'hFC, 32'h0000_0000);
        finish_test();
    end
endmodule
